// file: tb/nv_prog_model.sv
// partner: the programmer that burns both configuration words
// assumes the bench hands it the field values and a request level
module nv_prog_model (
  // field values to burn
  input wire cfg_words_pkg::cfg_fields_t cfg,
  input wire logic req_in,
  // stored words and programmer request
  output logic [31:0] nv_word0,
  output logic [31:0] nv_word1,
  output logic ext_access_req
);
  // ---------------------------------------
  // burned words
  // ---------------------------------------
  // word zero: top reserved bit zero, all other reserved bits one
  assign nv_word0 = {3'h3, cfg.code_protect_n, 3'h7, cfg.boot_write_protect_n, 5'h1F,
    cfg.program_write_protect_pages, 7'h7F, cfg.scan_port_enable, 2'h3};
  // word one: reserved bits one, primary osc mode kept off the disabled code
  assign nv_word1 = {6'h3F, cfg.wdog_window_size, cfg.wdog_fuse_enable,
    cfg.wdog_window_disable, 1'b1, cfg.wdog_postscale, 16'hFCFF};
  // request is a plain level, no timing of its own
  assign ext_access_req = req_in;
endmodule // nv_prog_model

// file: tb/test_device_config_words.sv
// bench for the configuration word loader
// assumes one pclk domain and apb access to the register view
module test_device_config_words;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------
  // stimulus and observed signals
  // ---------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1; // clock enable, dropped once to prove the freeze
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic ext_go = 1'b0;
  logic boot_write_req = 1'b0;
  cfg_words_pkg::cfg_fields_t cfg = '0;
  logic [31:0] prdata, nv_word0, nv_word1, rd;
  logic [31:0] prdata_small, rd_small;
  logic pready, pslverr, ext_access_req, ext_access_ok, boot_write_ok, err;
  logic cpu_fetch_en, scan_port_en, wdog_bite, wdog_running;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // 125 MHz clock
  always #4 pclk = ~pclk;
  nv_prog_model prog_u (.cfg(cfg), .req_in(ext_go), .nv_word0(nv_word0), .nv_word1(nv_word1),
    .ext_access_req(ext_access_req));
  device_config_words #(.LARGE_FLASH(1'b1)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nv_word0(nv_word0), .nv_word1(nv_word1),
    .ext_access_req(ext_access_req), .boot_write_req(boot_write_req), .ext_access_ok(ext_access_ok),
    .boot_write_ok(boot_write_ok), .cpu_fetch_en(cpu_fetch_en), .scan_port_en(scan_port_en),
    .wdog_bite(wdog_bite), .wdog_running(wdog_running));
  // small-memory variant on the same bus: only its word zero readback is compared
  device_config_words #(.LARGE_FLASH(1'b0)) dut_small_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_small), .pready(), .pslverr(), .nv_word0(nv_word0), .nv_word1(nv_word1),
    .ext_access_req(ext_access_req), .boot_write_req(boot_write_req), .ext_access_ok(),
    .boot_write_ok(), .cpu_fetch_en(), .scan_port_en(), .wdog_bite(), .wdog_running());
  // ---------------------------------------
  // shared tasks
  // ---------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready, only the hang guard ends the wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    rd_small = prdata_small;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // burn new words, reset for six cycles, wait for the first fetch
  task automatic boot(input cfg_words_pkg::cfg_fields_t c);
    int n;
    n = 0;
    cfg <= c;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    while (cpu_fetch_en !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= 133 && n < 400}, 32'h1);
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard: a run this long means a wait never ended
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      test_done;
    end
  end
  // ---------------------------------------
  // main sequence
  // ---------------------------------------
  initial begin
    // protected part, fuse watchdog with shortest timeout
    boot('{1'b0, 1'b1, 9'h1FF, 1'b1, 2'h3, 1'b1, 1'b1, 5'h00});
    ext_go <= 1'b1;
    boot_write_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, ext_access_ok}, 32'h0);
    chk({31'h0, boot_write_ok}, 32'h1);
    chk({31'h0, scan_port_en}, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h8, 32'h8);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, nv_word0);
    apb(1'b1, 8'h00, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, nv_word0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, nv_word1);
    // unmapped place answers with an error and zero
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // software tries to stop a fused watchdog
    apb(1'b1, 8'h0C, 32'h0);
    chk({31'h0, wdog_running}, 32'h1);
    chk({31'h0, wdog_bite}, 32'h1);
    // open part, soft watchdog, window mode, clamped postscale
    boot('{1'b1, 1'b0, 9'h0A5, 1'b0, 2'h0, 1'b0, 1'b0, 5'h1F});
    repeat (3) @(posedge pclk);
    chk({31'h0, ext_access_ok}, 32'h1);
    chk({31'h0, boot_write_ok}, 32'h0);
    chk({31'h0, scan_port_en}, 32'h0);
    chk({31'h0, wdog_running}, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, nv_word0);
    chk(rd_small, nv_word0 | 32'h00060000);
    apb(1'b1, 8'h08, 32'h8);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h8, 32'h8);
    apb(1'b1, 8'h0C, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, wdog_running}, 32'h1);
    chk({31'h0, wdog_bite}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h2);
    // clear long before the window opens
    apb(1'b1, 8'h0C, 32'h3);
    // freeze: the pending clear must wait until the enable returns
    ce <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({31'h0, wdog_bite}, 32'h0);
    ce <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({31'h0, wdog_bite}, 32'h1);
    test_done;
  end
endmodule // test_device_config_words

// file: verilog/cfg_words_pkg.sv
// package for the configuration word loader: offsets, field layout, timing
// assumes an apb master on pclk at 125 MHz and a config store outside
package cfg_words_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_WORD0 = 8'h00;
  localparam logic [7:0] ADDR_WORD1 = 8'h04;
  localparam logic [7:0] ADDR_RUNCFG = 8'h08;
  localparam logic [7:0] ADDR_WDOG = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CODE_PROT_BIT = 28;
  localparam int BOOT_WP_BIT = 24;
  localparam int PROG_WP_HI = 18; // nine page bits run from 18 down to 10
  localparam int PROG_WP_LO = 10;
  localparam int PROG_WP_TOP2_LO = 17; // upper two page bits, large parts only
  localparam int SCAN_BIT = 2;
  localparam int WSZ_LO = 24;
  localparam int FWEN_BIT = 23;
  localparam int WDIS_BIT = 22;
  localparam int WPS_LO = 16;
  localparam int RUN_SCAN_BIT = 3;
  localparam int WD_ON_BIT = 0;
  localparam int WD_CLR_BIT = 1;
  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam logic [4:0] PS_MAX = 5'h14;
  localparam logic [31:0] ERASED = 32'hFFFFFFFF;
  localparam logic [31:0] W0_RSV_MASK = 32'h80000000;
  localparam int CLK_MHZ = 125;
  localparam int RELOAD_NS = 1000;
  localparam int RELOAD_CYC = (RELOAD_NS * CLK_MHZ + 999) / 1000;
  localparam int SYS_DLY_CYC = 8;
  localparam int WD_BASE_CYC = 16;
  localparam logic [31:0] STAT_IDLE = 32'h00000000;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic code_protect_n;
    logic boot_write_protect_n;
    logic [8:0] program_write_protect_pages;
    logic scan_port_enable;
    logic [1:0] wdog_window_size;
    logic wdog_fuse_enable;
    logic wdog_window_disable;
    logic [4:0] wdog_postscale;
  } cfg_fields_t;
endpackage : cfg_words_pkg

// file: verilog/device_config_words.sv
// configuration word loader with apb view, run gate and watchdog
// assumes the config store presents both words steadily after power-up
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
module device_config_words (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // non-volatile words
  input wire logic [31:0] nv_word0,
  input wire logic [31:0] nv_word1,
  // access requests from programmer and cpu
  input wire logic ext_access_req,
  input wire logic boot_write_req,
  // results
  output logic ext_access_ok,
  output logic boot_write_ok,
  output logic cpu_fetch_en,
  output logic scan_port_en,
  output logic wdog_bite,
  output logic wdog_running
);
  parameter bit LARGE_FLASH = 1'b1; // larger program memory variant
  // ----------------------------------------
  // load sequence
  // ----------------------------------------
  typedef enum logic [1:0] {S_RELOAD, S_DELAY, S_RUN} load_state_t;
  load_state_t st_q;
  logic [7:0] dly_q;
  logic [31:0] w0_q;
  logic [31:0] w1_q;
  cfg_words_pkg::cfg_fields_t f;
  // sync of word inputs through three flops
  logic [31:0] s0a_q, s0b_q, s0c_q, s1a_q, s1b_q, s1c_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s0a_q <= 32'h00000000;
      s0b_q <= 32'h00000000;
      s0c_q <= 32'h00000000;
      s1a_q <= 32'h00000000;
      s1b_q <= 32'h00000000;
      s1c_q <= 32'h00000000;
    end else if (ce) begin
      s0a_q <= nv_word0;
      s0b_q <= s0a_q;
      s0c_q <= s0b_q;
      s1a_q <= nv_word1;
      s1b_q <= s1a_q;
      s1c_q <= s1b_q;
    end
  end
  // unimplemented protect bits read as one (erased) on small parts
  logic [31:0] wp_top_mask;
  assign wp_top_mask = LARGE_FLASH ? 32'h00000000 : (32'h00000003 << cfg_words_pkg::PROG_WP_TOP2_LO);
  // reload waits out the fixed time, then the system delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_RELOAD;
      dly_q <= 8'h00;
      w0_q <= cfg_words_pkg::ERASED;
      w1_q <= cfg_words_pkg::ERASED;
    end else if (ce) begin
      case (st_q)
        S_RELOAD: begin
          if (dly_q == 8'(cfg_words_pkg::RELOAD_CYC - 1)) begin
            w0_q <= (s0c_q & s0b_q) | wp_top_mask;
            w1_q <= s1c_q & s1b_q;
            dly_q <= 8'h00;
            st_q <= S_DELAY;
          end else begin
            dly_q <= dly_q + 8'h01;
          end
        end
        S_DELAY: begin
          if (dly_q == 8'(cfg_words_pkg::SYS_DLY_CYC - 1)) begin
            st_q <= S_RUN;
          end else begin
            dly_q <= dly_q + 8'h01;
          end
        end
        S_RUN: st_q <= S_RUN; // fields frozen
        default: st_q <= S_RELOAD;
      endcase
    end
  end
  // ----------------------------------------
  // field decode
  // ----------------------------------------
  assign f.code_protect_n = w0_q[cfg_words_pkg::CODE_PROT_BIT];
  assign f.boot_write_protect_n = w0_q[cfg_words_pkg::BOOT_WP_BIT];
  assign f.program_write_protect_pages = w0_q[cfg_words_pkg::PROG_WP_HI -: 9];
  assign f.scan_port_enable = w0_q[cfg_words_pkg::SCAN_BIT];
  assign f.wdog_window_size = w1_q[cfg_words_pkg::WSZ_LO +: 2];
  assign f.wdog_fuse_enable = w1_q[cfg_words_pkg::FWEN_BIT];
  assign f.wdog_window_disable = w1_q[cfg_words_pkg::WDIS_BIT];
  assign f.wdog_postscale = w1_q[cfg_words_pkg::WPS_LO +: 5];
  logic running;
  assign running = (st_q == S_RUN);
  // ----------------------------------------
  // run-time registers
  // ----------------------------------------
  logic scan_q, wd_sw_on_q, wd_clr_q, run_d;
  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite && running;
  assign rd_en = psel && !penable && !pwrite;
  assign run_d = f.wdog_fuse_enable || wd_sw_on_q;
  // scan bit seeded at load, software writable after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_q <= 1'b0;
      wd_sw_on_q <= 1'b0;
      wd_clr_q <= 1'b0;
    end else if (ce) begin
      wd_clr_q <= 1'b0;
      if (st_q == S_DELAY) begin
        scan_q <= f.scan_port_enable;
      end else if (wr_en && paddr == cfg_words_pkg::ADDR_RUNCFG) begin
        scan_q <= pwdata[cfg_words_pkg::RUN_SCAN_BIT];
      end
      if (wr_en && paddr == cfg_words_pkg::ADDR_WDOG) begin
        wd_sw_on_q <= pwdata[cfg_words_pkg::WD_ON_BIT]; // ignored under fuse
        wd_clr_q <= pwdata[cfg_words_pkg::WD_CLR_BIT];
      end
    end
  end
  // watchdog
  logic bite;
  wdog_core u_wdog (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(run_d && running),
    .clr(wd_clr_q),
    .postscale(f.wdog_postscale),
    .win_size(f.wdog_window_size),
    .win_dis(f.wdog_window_disable),
    .bite(bite)
  );
  // ----------------------------------------
  // read mux and apb answer
  // ----------------------------------------
  logic [31:0] rd_mux;
  logic known;
  assign known = (paddr == cfg_words_pkg::ADDR_WORD0) || (paddr == cfg_words_pkg::ADDR_WORD1) ||
                 (paddr == cfg_words_pkg::ADDR_RUNCFG) || (paddr == cfg_words_pkg::ADDR_WDOG) ||
                 (paddr == cfg_words_pkg::ADDR_STATUS);
  assign rd_mux = (paddr == cfg_words_pkg::ADDR_WORD0) ? w0_q :
                  (paddr == cfg_words_pkg::ADDR_WORD1) ? w1_q :
                  (paddr == cfg_words_pkg::ADDR_RUNCFG) ? (32'(scan_q) << cfg_words_pkg::RUN_SCAN_BIT) :
                  (paddr == cfg_words_pkg::ADDR_WDOG) ? {30'h0, 1'b0, run_d} :
                  (paddr == cfg_words_pkg::ADDR_STATUS) ? {29'h0, bite, running, st_q == S_DELAY} :
                  cfg_words_pkg::STAT_IDLE;
  // single wait-free access; error on unmapped or config word write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (!known || (pwrite && paddr <= cfg_words_pkg::ADDR_WORD1));
      if (rd_en) begin
        prdata <= rd_mux;
      end
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_access_ok <= 1'b0;
      boot_write_ok <= 1'b0;
      cpu_fetch_en <= 1'b0;
      scan_port_en <= 1'b0;
      wdog_bite <= 1'b0;
      wdog_running <= 1'b0;
    end else if (ce) begin
      ext_access_ok <= ext_access_req && running && f.code_protect_n;
      boot_write_ok <= boot_write_req && running && f.boot_write_protect_n;
      cpu_fetch_en <= running;
      scan_port_en <= scan_q;
      wdog_bite <= bite;
      wdog_running <= run_d && running;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_ext_access_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ext_access_ok |-> $past(f.code_protect_n)) else $error("external access while protected");
  a_boot_write_gate: assert property (@(posedge pclk) disable iff (!presetn)
    boot_write_ok |-> $past(f.boot_write_protect_n)) else $error("boot write while protected");
  a_fuse_keeps_wdog: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && running && f.wdog_fuse_enable) |=> wdog_running) else $error("watchdog stopped under fuse");
  a_fuse_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !f.wdog_fuse_enable && !wd_sw_on_q) |=> !wdog_running) else $error("watchdog ran unasked");
  a_scan_seed: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && st_q == S_DELAY) |=> scan_q == $past(f.scan_port_enable)) else $error("scan seed lost");
  a_fetch_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cpu_fetch_en) |-> ($past(st_q, 2) == S_DELAY)) else $error("fetch before delay");
  a_fields_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (running && $past(running)) |-> $stable(w0_q) && $stable(w1_q)) else $error("fields changed");
  a_no_early_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == S_RELOAD) |-> !cpu_fetch_en) else $error("fetch during reload");
  // small parts must show the absent page bits as erased once loaded
  a_small_part_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (!LARGE_FLASH && running) |-> (w0_q[cfg_words_pkg::PROG_WP_TOP2_LO +: 2] == 2'h3))
    else $error("absent protect bits not erased");
  // a write aimed at loaded word zero is answered with an error
  a_word_write_err: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && psel && !penable && pwrite && paddr == cfg_words_pkg::ADDR_WORD0) |=> pslverr)
    else $error("config word write not refused");
endmodule // device_config_words

// file: verilog/wdog_core.sv
// watchdog counter with postscale and window check
// assumes the config fields are stable once loaded
module wdog_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic clr,
  input wire logic [4:0] postscale,
  input wire logic [1:0] win_size,
  input wire logic win_dis,
  // result
  output logic bite
);
  // ----------------------------------------
  // timeout and window
  // ----------------------------------------
  logic [4:0] ps_eff;
  logic [31:0] timeout;
  logic [31:0] open_at;
  logic [31:0] cnt_q;
  assign ps_eff = (postscale > cfg_words_pkg::PS_MAX) ? cfg_words_pkg::PS_MAX : postscale;
  assign timeout = 32'(cfg_words_pkg::WD_BASE_CYC) << ps_eff;
  // closed fraction: 75, 62.5, 50, 25 percent of timeout
  assign open_at = (win_size == 2'b11) ? (timeout - (timeout >> 2)) :
                   (win_size == 2'b10) ? ((timeout >> 1) + (timeout >> 3)) :
                   (win_size == 2'b01) ? (timeout >> 1) : (timeout >> 2);
  // early clear is only a fault when windowed
  logic early;
  assign early = clr && !win_dis && (cnt_q < open_at);
  // counter and bite; bite held until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h00000000;
      bite <= 1'b0;
    end else if (ce) begin
      if (!run || clr) begin
        cnt_q <= 32'h00000000;
      end else begin
        cnt_q <= cnt_q + 32'h00000001;
      end
      if (run && (early || cnt_q >= timeout - 32'h00000001)) begin
        bite <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_early_clear_bite: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && run && clr && !win_dis && (cnt_q < open_at)) |=> bite) else $error("early clear not punished");
  // plain mode: a clear well before timeout must never bite
  a_plain_clear_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && run && clr && win_dis && !bite && (cnt_q < timeout - 32'h00000001)) |=> !bite)
    else $error("plain mode clear caused bite");
endmodule // wdog_core
